/* File: hmc_defines.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef HMC_DEFINES_SVH
`define HMC_DEFINES_SVH

`define HMC_REG_CTRL       4'h0
`define HMC_REG_IS_ADDR    4'h1
`define HMC_REG_FD_ADDR    4'h2
`define HMC_REG_STATUS     4'h3
`define HMC_REG_IS_SEEN    4'h4
`define HMC_REG_FD_SEEN    4'h5
`define HMC_REG_SLAVE_VAL  4'h6

`define HMC_CTRL_MODE_LSB  0
`define HMC_CTRL_MODE_MSB  1

`define HMC_ST_MODE_LSB    0
`define HMC_ST_MODE_MSB    1
`define HMC_ST_FITTED      2
`define HMC_ST_ADDR0_ALARM 3
`define HMC_ST_DUP_ALARM   4
`define HMC_ST_BUSY        5

`define HMC_IS_ADDR_RST    4'hf
`define HMC_FD_ADDR_RST    4'h0
`define HMC_SLAVE_VAL_RST  16'h0000
`define HMC_LAST_ADDR      4'hf

`define HMC_CLK_MHZ        40
`define HMC_POLL_US        1000
`define HMC_ANSWER_US      500
`define HMC_POLL_CYC       (`HMC_CLK_MHZ * `HMC_POLL_US)
`define HMC_ANSWER_CYC     (`HMC_CLK_MHZ * `HMC_ANSWER_US)

`endif

/* File: hmc_pkg.sv */
// Types shared by the dual port mode control block.
package hmc_pkg;

    typedef enum logic [1:0] {
        HMC_MODE_ANALOG = 2'h0,
        HMC_MODE_SLAVE  = 2'h1,
        HMC_MODE_MASTER = 2'h2
    } hmc_mode_t;

    typedef enum logic [1:0] {
        HMC_ST_IDLE = 2'b01,
        HMC_ST_WAIT = 2'b10
    } hmc_state_t;

    typedef struct packed {
        hmc_mode_t   mode;
        logic [3:0]  is_addr;
        logic [3:0]  fd_addr;
        logic [15:0] slave_val;
        logic [15:0] is_seen;
        logic [15:0] fd_seen;
        logic [15:0] rdata;
        logic [2:0]  fit_sync;
        logic        fitted;
        hmc_state_t  state;
        logic        poll_bus;
        logic [3:0]  poll_addr;
        logic [15:0] tick_cnt;
        logic [15:0] wait_cnt;
        logic        poll_req;
        logic        is_resp;
        logic        fd_resp;
        logic [3:0]  resp_addr_is;
        logic [3:0]  resp_addr_fd;
    } hmc_state_regs_t;

endpackage

/* File: hmc_mode_ctrl.sv */
// Mode, addressing and polling control for the two HART ports.
`timescale 1ns/1ps
`include "hmc_defines.svh"

module hmc_mode_ctrl
    import hmc_pkg::*;
#(
    parameter int POLL_CYCLES   = `HMC_POLL_CYC,
    parameter int ANSWER_CYCLES = `HMC_ANSWER_CYC
) (
    input  wire logic        clock_in,          // 40 MHz system clock
    input  wire logic        rst_in,            // async reset, active high
    input  wire logic [3:0]  reg_addr_in,       // register index
    input  wire logic [15:0] reg_wdata_in,      // register write data
    input  wire logic        reg_wr_in,         // write strobe
    input  wire logic        reg_rd_in,         // read strobe
    output logic      [15:0] reg_rdata_out,     // read data, cycle after
    input  wire logic        analog_fitted_in,  // variant strap pin
    input  wire logic        is_rx_valid_in,    // safe-bus request frame
    input  wire logic [3:0]  is_rx_addr_in,     // its polling address
    input  wire logic        fd_rx_valid_in,    // flameproof request frame
    input  wire logic [3:0]  fd_rx_addr_in,     // its polling address
    input  wire logic        poll_done_in,      // poll transaction ended
    input  wire logic        poll_found_in,     // instrument answered
    output logic             poll_req_out,      // start one poll, pulse
    output logic             poll_bus_out,      // 0 safe bus, 1 flameproof
    output logic      [3:0]  poll_addr_out,     // address being polled
    output logic             is_master_en_out,  // safe-bus master active
    output logic             is_slave_resp_out, // safe-bus answer, pulse
    output logic      [3:0]  is_resp_addr_out,  // address to answer with
    output logic             fd_slave_resp_out, // flameproof answer, pulse
    output logic      [3:0]  fd_resp_addr_out,  // address to answer with
    output logic      [15:0] slave_val_out,     // shared slave values
    output logic             fd_hart_en_out,    // HART modem on flameproof
    output logic             fd_loop_live_out,  // current follows value
    output logic             fd_loop_fixed_out, // current held fixed
    output logic             addr_alarm_out     // address check alarm
);

    ////////////////////////////////////////////////////////////////////////

    // Both counters start at zero, so each compares against one less than
    // its period; the default periods fit the sixteen-bit counters.
    localparam logic [15:0] POLL_LAST   = 16'(POLL_CYCLES - 1);
    localparam logic [15:0] ANSWER_LAST = 16'(ANSWER_CYCLES - 1);

    hmc_state_regs_t r;
    hmc_state_regs_t next_r;

    // Decoded views of the registered state, shared by the processes below.
    hmc_mode_t  eff_mode;
    logic       mode_analog;
    logic       mode_slave;
    logic       mode_master;
    logic       addr0_alarm;
    logic       dup_alarm;
    logic       poll_tick;
    logic       scan_end;

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        // no flameproof bus
        // Without analog hardware the port is forced to its quiet mode.
        eff_mode = r.fitted ? r.mode : HMC_MODE_ANALOG;
        mode_analog = (eff_mode == HMC_MODE_ANALOG);
        mode_slave  = (eff_mode == HMC_MODE_SLAVE);
        mode_master = (eff_mode == HMC_MODE_MASTER);

        addr0_alarm = r.is_seen[0] | r.fd_seen[0];
        // loops independent
        // Duplicates only matter while one master owns both buses.
        dup_alarm = mode_master && ((r.is_seen & r.fd_seen) != 16'h0000);

        // The scan of one bus ends after its highest address.
        poll_tick = (r.tick_cnt == POLL_LAST);
        scan_end = (r.poll_addr == `HMC_LAST_ADDR);
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_r = r;
        next_r.poll_req = 1'b0;
        next_r.is_resp = 1'b0;
        next_r.fd_resp = 1'b0;
        next_r.rdata = 16'h0000;

        // A strap change counts only once the last two stages agree.
        next_r.fit_sync = {r.fit_sync[1:0], analog_fitted_in};
        if (r.fit_sync[1] == r.fit_sync[2]) begin
            next_r.fitted = r.fit_sync[2];
        end

        if (reg_wr_in) begin
            case (reg_addr_in)
                `HMC_REG_CTRL: begin
                    // Code 3 has no mode of its own and falls back to the
                    // quiet analog setting rather than an undefined one.
                    case (reg_wdata_in[`HMC_CTRL_MODE_MSB:
                                       `HMC_CTRL_MODE_LSB])
                        2'h1: begin
                            next_r.mode = HMC_MODE_SLAVE;
                        end
                        2'h2: begin
                            next_r.mode = HMC_MODE_MASTER;
                        end
                        default: begin
                            next_r.mode = HMC_MODE_ANALOG;
                        end
                    endcase
                end
                `HMC_REG_IS_ADDR: begin
                    next_r.is_addr = reg_wdata_in[3:0];
                end
                `HMC_REG_FD_ADDR: begin
                    next_r.fd_addr = reg_wdata_in[3:0];
                end
                `HMC_REG_SLAVE_VAL: begin
                    next_r.slave_val = reg_wdata_in;
                end
                default: begin
                end
            endcase
        end

        // Read data stand for one cycle and are zero otherwise, so a stale
        // value can never be mistaken for a fresh answer.
        if (reg_rd_in) begin
            case (reg_addr_in)
                `HMC_REG_CTRL: begin
                    next_r.rdata = {14'h0000, r.mode};
                end
                `HMC_REG_IS_ADDR: begin
                    next_r.rdata = {12'h000, r.is_addr};
                end
                `HMC_REG_FD_ADDR: begin
                    next_r.rdata = {12'h000, r.fd_addr};
                end
                `HMC_REG_STATUS: begin
                    // The effective mode is shown, not the written one.
                    next_r.rdata[`HMC_ST_MODE_MSB:`HMC_ST_MODE_LSB] =
                        eff_mode;
                    next_r.rdata[`HMC_ST_FITTED] = r.fitted;
                    next_r.rdata[`HMC_ST_ADDR0_ALARM] = addr0_alarm;
                    next_r.rdata[`HMC_ST_DUP_ALARM] = dup_alarm;
                    next_r.rdata[`HMC_ST_BUSY] = (r.state == HMC_ST_WAIT);
                end
                `HMC_REG_IS_SEEN: begin
                    next_r.rdata = r.is_seen;
                end
                `HMC_REG_FD_SEEN: begin
                    next_r.rdata = r.fd_seen;
                end
                `HMC_REG_SLAVE_VAL: begin
                    next_r.rdata = r.slave_val;
                end
                default: begin
                    next_r.rdata = 16'h0000;
                end
            endcase
        end

        // The safe-bus slave answers in every flameproof mode.
        // safe-bus slave
        if (is_rx_valid_in && (is_rx_addr_in == r.is_addr)) begin
            next_r.is_resp = 1'b1;
            next_r.resp_addr_is = r.is_addr;
        end

        // In master mode the safe-bus address is the only slave address.
        // flameproof slave
        if (fd_rx_valid_in) begin
            if (mode_slave && (fd_rx_addr_in == r.fd_addr)) begin
                next_r.fd_resp = 1'b1;
                next_r.resp_addr_fd = r.fd_addr;
            end else if (mode_master && (fd_rx_addr_in == r.is_addr)) begin
                next_r.fd_resp = 1'b1;
                next_r.resp_addr_fd = r.is_addr;
            end
        end

        // The poll interval runs freely; a tick that lands while a poll
        // is still open is skipped rather than queued.
        if (poll_tick) begin
            next_r.tick_cnt = 16'h0000;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 16'h0001;
        end

        case (r.state)
            HMC_ST_IDLE: begin
                if (poll_tick) begin
                    // Each poll gets its own answer window from zero.
                    next_r.poll_req = 1'b1;
                    next_r.wait_cnt = 16'h0000;
                    next_r.state = HMC_ST_WAIT;
                end
            end
            HMC_ST_WAIT: begin
                if (poll_done_in || (r.wait_cnt == ANSWER_LAST)) begin
                    // A timeout clears the bit, so a removed instrument
                    // drops out of the map on its next poll.
                    // record found
                    if (r.poll_bus) begin
                        next_r.fd_seen[r.poll_addr] =
                            poll_done_in & poll_found_in;
                    end else begin
                        next_r.is_seen[r.poll_addr] =
                            poll_done_in & poll_found_in;
                    end
                    // Address 0 is polled too, so a misaddressed instrument
                    // raises the alarm; the address wraps from the last
                    // back to 0 by itself.
                    next_r.poll_addr = r.poll_addr + 4'h1;
                    if (scan_end) begin
                        next_r.poll_bus = mode_master & ~r.poll_bus;
                    end
                    next_r.state = HMC_ST_IDLE;
                end else begin
                    next_r.wait_cnt = r.wait_cnt + 16'h0001;
                end
            end
            default: next_r.state = HMC_ST_IDLE;
        endcase

        // Stale flameproof results would raise false duplicate alarms.
        if (!mode_master) begin
            next_r.fd_seen = 16'h0000;
            if (r.state == HMC_ST_IDLE) begin
                next_r.poll_bus = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            r.mode <= HMC_MODE_ANALOG;
            r.is_addr <= `HMC_IS_ADDR_RST;
            r.fd_addr <= `HMC_FD_ADDR_RST;
            r.slave_val <= `HMC_SLAVE_VAL_RST;

            // Observed maps start empty until the first scan has run.
            r.is_seen <= 16'h0000;
            r.fd_seen <= 16'h0000;
            r.rdata <= 16'h0000;

            // The strap reads as absent until the synchroniser settles.
            r.fit_sync <= 3'h0;
            r.fitted <= 1'b0;

            r.state <= HMC_ST_IDLE;
            r.poll_bus <= 1'b0;
            r.poll_addr <= 4'h0;
            r.tick_cnt <= 16'h0000;
            r.wait_cnt <= 16'h0000;

            r.poll_req <= 1'b0;
            r.is_resp <= 1'b0;
            r.fd_resp <= 1'b0;
            r.resp_addr_is <= 4'h0;
            r.resp_addr_fd <= 4'h0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        reg_rdata_out = r.rdata;

        poll_req_out = r.poll_req;
        poll_bus_out = r.poll_bus;
        poll_addr_out = r.poll_addr;

        is_master_en_out = 1'b1;

        is_slave_resp_out = r.is_resp;
        is_resp_addr_out = r.resp_addr_is;
        fd_slave_resp_out = r.fd_resp;
        fd_resp_addr_out = r.resp_addr_fd;

        slave_val_out = r.slave_val;

        fd_hart_en_out = mode_slave | mode_master;

        // Live current flows only in analog mode or at slave address 0;
        // a variant without analog hardware drives neither current.
        // fixed current
        fd_loop_live_out = r.fitted &
            (mode_analog | (mode_slave & (r.fd_addr == 4'h0)));
        fd_loop_fixed_out = r.fitted & ~mode_analog &
            ~(mode_slave & (r.fd_addr == 4'h0));

        addr_alarm_out = addr0_alarm | dup_alarm;
    end

endmodule

/* File: hmc_mode_ctrl_sva.sv */
// Concurrent checks on the ports of the mode control block.
`timescale 1ns/1ps
module hmc_mode_ctrl_chk #(
    parameter int POLL_CYCLES   = 20,
    parameter int ANSWER_CYCLES = 8
) (
    input wire logic        clock_in,          // clock
    input wire logic        rst_in,            // reset
    input wire logic        reg_rd_in,         // read strobe
    input wire logic [15:0] reg_rdata_out,     // read data
    input wire logic        is_rx_valid_in,    // safe frame
    input wire logic [3:0]  is_rx_addr_in,     // its address
    input wire logic        fd_rx_valid_in,    // flameproof frame
    input wire logic [3:0]  fd_rx_addr_in,     // its address
    input wire logic        poll_req_out,      // poll pulse
    input wire logic        poll_bus_out,      // polled bus
    input wire logic        is_slave_resp_out, // safe answer
    input wire logic [3:0]  is_resp_addr_out,  // answer address
    input wire logic        fd_slave_resp_out, // flameproof answer
    input wire logic [3:0]  fd_resp_addr_out,  // answer address
    input wire logic        fd_hart_en_out,    // modem on
    input wire logic        fd_loop_live_out,  // live current
    input wire logic        fd_loop_fixed_out  // fixed current
);
    // A poll may wait a whole answer time and then a whole tick period.
    localparam int GAP = POLL_CYCLES + ANSWER_CYCLES + 4;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    property p_is_ans; is_slave_resp_out |-> $past(is_rx_valid_in)
        && is_resp_addr_out == $past(is_rx_addr_in); endproperty
    a_is_ans: assert property (p_is_ans)
        else $error("safe-bus answer without matching frame");
    property p_fd_ans; fd_slave_resp_out |-> $past(fd_rx_valid_in)
        && fd_resp_addr_out == $past(fd_rx_addr_in); endproperty
    a_fd_ans: assert property (p_fd_ans)
        else $error("flameproof answer without matching frame");
    property p_fd_gate;
        fd_slave_resp_out |-> $past(fd_hart_en_out); endproperty
    a_fd_gate: assert property (p_fd_gate)
        else $error("flameproof answer while its modem is off");
    property p_multidrop; fd_slave_resp_out && fd_resp_addr_out != 4'h0
        |-> fd_loop_fixed_out && !fd_loop_live_out; endproperty
    a_multidrop: assert property (p_multidrop)
        else $error("nonzero address without fixed current");
    property p_addr0_live; fd_slave_resp_out && fd_resp_addr_out == 4'h0
        |-> fd_loop_live_out && !fd_loop_fixed_out; endproperty
    a_addr0_live: assert property (p_addr0_live)
        else $error("address zero without live current");
    property p_rd_stand;
        reg_rdata_out != 16'h0 |-> $past(reg_rd_in); endproperty
    a_rd_stand: assert property (p_rd_stand)
        else $error("read data outside its cycle");
    property p_poll_again; poll_req_out |-> ##[1:GAP] poll_req_out; endproperty
    a_poll_again: assert property (p_poll_again)
        else $error("cyclic polling stalled");
    property p_fd_poll; poll_req_out && poll_bus_out
        |-> fd_hart_en_out && fd_loop_fixed_out; endproperty
    a_fd_poll: assert property (p_fd_poll)
        else $error("flameproof poll outside master mode");
    c_is_ans: cover property (is_slave_resp_out);
    c_fd_ans: cover property (fd_slave_resp_out);
    c_fd_poll: cover property (poll_req_out && poll_bus_out);
endmodule

/* File: hmc_field_model.sv */
// Behavioural field instruments answering the block's poll requests.
`timescale 1ns/1ps
module hmc_field_model (
    input  wire logic        clock_in,      // clock
    input  wire logic        rst_in,        // reset
    input  wire logic        poll_req_in,   // poll start
    input  wire logic        poll_bus_in,   // polled bus
    input  wire logic [3:0]  poll_addr_in,  // polled address
    input  wire logic [15:0] is_map_in,     // safe-bus instruments
    input  wire logic [15:0] fd_map_in,     // flameproof instruments
    input  wire logic [3:0]  lag_in,        // answer delay, nonzero
    output logic             poll_done_out, // answer pulse
    output logic             poll_found_out // instrument found
);
    logic [3:0]  cnt;
    logic [15:0] map;
    assign map = poll_bus_in ? fd_map_in : is_map_in;
    // only instruments at the polled address answer.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 4'h0;
            poll_done_out <= 1'b0;
            poll_found_out <= 1'b0;
        end else begin
            poll_done_out <= cnt == 4'h1;
            // Found toggles outside answers so a stale level cannot pass.
            poll_found_out <= (cnt == 4'h1) | ~poll_found_out;
            if (poll_req_in && map[poll_addr_in])
                cnt <= lag_in;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

/* File: hmc_mode_ctrl_tb.sv */
// Self-checking bench for the dual port mode control block.
`timescale 1ns/1ps
`include "hmc_defines.svh"
module hmc_mode_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, fit = 1'b1;
    logic        is_v = 1'b0, fd_v = 1'b0, done, found, req, bus, is_r, fd_r;
    logic        hart, live, fixd, alarm, mst;
    logic [3:0]  ra = 4'h0, fa = 4'h0, lag = 4'h1, p_a, is_ra, fd_ra;
    logic [15:0] wd = 16'h0000, rdat, sval, lf = 16'h27c9;
    logic [15:0] is_map = 16'h002e, fd_map = 16'h0000;
    int          miscompares = 0, cmp_count = 0, m_is = 15, m_fd = 0, m_md = 0;
    hmc_mode_ctrl #(.POLL_CYCLES(20), .ANSWER_CYCLES(8)) uut (
        .clock_in(clk), .rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdat),
        .analog_fitted_in(fit), .is_rx_valid_in(is_v), .is_rx_addr_in(fa),
        .fd_rx_valid_in(fd_v), .fd_rx_addr_in(fa), .poll_done_in(done),
        .poll_found_in(found), .poll_req_out(req), .poll_bus_out(bus),
        .poll_addr_out(p_a), .is_master_en_out(mst), .is_slave_resp_out(is_r),
        .is_resp_addr_out(is_ra), .fd_slave_resp_out(fd_r),
        .fd_resp_addr_out(fd_ra), .slave_val_out(sval), .fd_hart_en_out(hart),
        .fd_loop_live_out(live), .fd_loop_fixed_out(fixd),
        .addr_alarm_out(alarm));
    hmc_field_model fm (
        .clock_in(clk), .rst_in(rst), .poll_req_in(req), .poll_bus_in(bus),
        .poll_addr_in(p_a), .is_map_in(is_map), .fd_map_in(fd_map),
        .lag_in(lag), .poll_done_out(done), .poll_found_out(found));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected modem, live and fixed flags of the flameproof loop.
    function automatic logic [2:0] loop_exp();
        if (!fit) return 3'b000;
        case (m_md)
            1: return m_fd == 0 ? 3'b110 : 3'b101;
            2: return 3'b101;
            default: return 3'b010;
        endcase
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        if (a == `HMC_REG_CTRL) m_md = d[1:0] == 2'h3 ? 0 : d[1:0];
        if (a == `HMC_REG_IS_ADDR) m_is = d[3:0];
        if (a == `HMC_REG_FD_ADDR) m_fd = d[3:0];
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] want,
                      input logic [15:0] mk = 16'hffff);
        @(posedge clk);
        rd_s <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdat & mk, want);
    endtask
    task automatic frame(input logic f, input logic [3:0] a);
        logic hit;
        hit = f ? fit && (m_md == 1 ? a == m_fd : m_md == 2 && a == m_is)
                : a == m_is;
        @(posedge clk);
        is_v <= !f;
        fd_v <= f;
        fa <= a;
        @(posedge clk);
        is_v <= 1'b0;
        fd_v <= 1'b0;
        #1 chk({fd_r, is_r}, {hit & f, hit & !f});
        if (hit) chk(f ? fd_ra : is_ra, a);
    endtask
    // Waits for the poll of address 15 on the given bus, then its answer.
    task automatic scan(input logic b);
        int n;
        n = 0;
        while (!(req && bus == b && p_a == 4'hf) && n < 2500) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 2500) begin
            miscompares++;
            close_out();
        end else begin
            repeat (12) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(mst, 1'b1);
        chk({hart, live, fixd}, loop_exp());
        rd(`HMC_REG_CTRL, 16'h0000);
        rd(`HMC_REG_IS_ADDR, 16'h000f);
        rd(`HMC_REG_FD_ADDR, 16'h0000);
        rd(4'h9, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            lf = nx(lf);
            if (i % 4 == 0) wr(`HMC_REG_IS_ADDR, {12'h000, lf[7:4]});
            frame(1'b0, i[0] ? lf[3:0] : 4'(m_is));
            frame(1'b1, lf[3:0]);
        end
        wr(`HMC_REG_IS_ADDR, 16'h000f);
        for (int m = 0; m < 5; m++) begin
            wr(`HMC_REG_CTRL, 16'(m == 4 ? 1 : m));
            wr(`HMC_REG_FD_ADDR, 16'(m == 4 ? 7 : 0));
            rd(`HMC_REG_STATUS, 16'(m_md) | 16'h0004, 16'h0007);
            chk({hart, live, fixd}, loop_exp());
            frame(1'b1, 4'(m_fd));
            frame(1'b1, 4'hf);
            lf = nx(lf);
            frame(1'b1, lf[3:0]);
        end
        wr(`HMC_REG_SLAVE_VAL, lf);
        @(posedge clk);
        #1 chk(sval, lf);
        rd(`HMC_REG_SLAVE_VAL, lf);
        fd_map = 16'h0060;
        wr(`HMC_REG_CTRL, 16'h0002);
        scan(1'b1);
        scan(1'b1);
        rd(`HMC_REG_IS_SEEN, is_map);
        rd(`HMC_REG_FD_SEEN, fd_map);
        rd(`HMC_REG_STATUS, 16'h0012, 16'h001b);
        chk(alarm, 1'b1);
        lag = 4'h5;
        fd_map = 16'h0240;
        is_map = 16'h002a;
        scan(1'b1);
        scan(1'b1);
        rd(`HMC_REG_FD_SEEN, fd_map);
        chk(alarm, 1'b0);
        rd(`HMC_REG_IS_SEEN, is_map);
        is_map = 16'h002f;
        wr(`HMC_REG_CTRL, 16'h0000);
        scan(1'b0);
        scan(1'b0);
        rd(`HMC_REG_STATUS, 16'h0008, 16'h001b);
        chk(alarm, 1'b1);
        @(posedge clk);
        fit <= 1'b0;
        wr(`HMC_REG_CTRL, 16'h0001);
        repeat (6) @(posedge clk);
        #1 chk({hart, live, fixd}, loop_exp());
        rd(`HMC_REG_STATUS, 16'h0000, 16'h0007);
        frame(1'b1, 4'(m_fd));
        close_out();
    end
endmodule
bind hmc_mode_ctrl hmc_mode_ctrl_chk #(.POLL_CYCLES(POLL_CYCLES),
    .ANSWER_CYCLES(ANSWER_CYCLES)) chk_i (.clock_in, .rst_in, .reg_rd_in,
    .reg_rdata_out, .is_rx_valid_in, .is_rx_addr_in, .fd_rx_valid_in,
    .fd_rx_addr_in, .poll_req_out, .poll_bus_out, .is_slave_resp_out,
    .is_resp_addr_out, .fd_slave_resp_out, .fd_resp_addr_out,
    .fd_hart_en_out, .fd_loop_live_out, .fd_loop_fixed_out);
